// *** include/cct_pkg.sv ***
// Package for the classic counter/timer pair: register map, field positions, modes, divider settings.
// Assumes an 8-bit register port and one system clock shared by every user of this package.
package cct_pkg;

	// Register offsets
	localparam logic [3:0] OFF_TIMER_CONTROL  = 4'h0;
	localparam logic [3:0] OFF_TIMER_MODE     = 4'h1;
	localparam logic [3:0] OFF_TIMER0_LOW     = 4'h2;
	localparam logic [3:0] OFF_TIMER0_HIGH    = 4'h3;
	localparam logic [3:0] OFF_TIMER1_LOW     = 4'h4;
	localparam logic [3:0] OFF_TIMER1_HIGH    = 4'h5;
	localparam logic [3:0] OFF_CLOCK_CONTROL  = 4'h6;
	localparam logic [3:0] OFF_EXT_INPUT_CFG  = 4'h7;
	localparam logic [3:0] OFF_IRQ_ENABLE     = 4'h8;

	// Field positions: timer_control_reg
	localparam int POS_TIMER0_RUN  = 4;
	localparam int POS_TIMER0_FLAG = 5;
	localparam int POS_TIMER1_RUN  = 6;
	localparam int POS_TIMER1_FLAG = 7;
	// Field positions: timer_mode_reg, per timer base 0 or 4
	localparam int POS_MODE_LSB    = 0;
	localparam int POS_CNT_SELECT  = 2;
	localparam int POS_GATE_ENABLE = 3;
	localparam int MODE_STRIDE     = 4;
	// Field positions: clock_control_reg
	localparam int POS_DIV_LSB     = 0;
	localparam int POS_SYSCLK_SEL0 = 2;
	localparam int POS_SYSCLK_SEL1 = 3;
	// Field positions: ext_input_config_reg and interrupt_enable_reg
	localparam int POS_POLARITY0   = 3;
	localparam int POS_POLARITY1   = 7;
	localparam int POS_IRQ_EN0     = 1;
	localparam int POS_IRQ_EN1     = 3;

	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Prescaler divisors
	localparam int unsigned DIV_SYS12 = 12;
	localparam int unsigned DIV_SYS4  = 4;
	localparam int unsigned DIV_SYS48 = 48;
	localparam int unsigned DIV_EXT8  = 8;

	typedef enum logic [1:0] {
		CCT_DIV_SYS12,
		CCT_DIV_SYS4,
		CCT_DIV_SYS48,
		CCT_DIV_EXT8
	} cct_div_e;

	typedef enum logic [1:0] {
		CCT_MODE_13BIT,
		CCT_MODE_16BIT,
		CCT_MODE_8BIT_RELOAD,
		CCT_MODE_SPLIT
	} cct_mode_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cct_bus_req_s;

	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] hi;
		logic       ovf;
	} cct_cnt_s;

endpackage : cct_pkg

// *** hw/cct_prescaler.sv ***
// Shared prescaler: one-cycle tick at system clock /12, /4, /48 or external clock /8.
// Assumes ext_clk is synchronous to sys_clk and each of its levels lasts at least one cycle.
module cct_prescaler (
	input  wire logic            sys_clk,
	input  wire logic            srst,
	input  wire logic            ext_clk,
	input  wire cct_pkg::cct_div_e div_sel,
	output logic                 tick
);

	logic [5:0] cnt_ff;
	logic       ext_ff;
	logic       ext_prev_ff;
	logic [5:0] limit;
	wire        ext_rise = ext_ff & ~ext_prev_ff;
	wire        step     = (div_sel == cct_pkg::CCT_DIV_EXT8) ? ext_rise : 1'b1;
	// Compare with >= so a smaller divisor written mid-count cannot strand the counter
	wire        at_limit = (cnt_ff >= limit);

	always_comb begin
		unique case (div_sel)
			cct_pkg::CCT_DIV_SYS12: limit = 6'(cct_pkg::DIV_SYS12 - 1);
			cct_pkg::CCT_DIV_SYS4:  limit = 6'(cct_pkg::DIV_SYS4 - 1);
			cct_pkg::CCT_DIV_SYS48: limit = 6'(cct_pkg::DIV_SYS48 - 1);
			cct_pkg::CCT_DIV_EXT8:  limit = 6'(cct_pkg::DIV_EXT8 - 1);
		endcase
	end

	assign tick = step & at_limit;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_ff      <= 6'h00;
			ext_ff      <= 1'b0;
			ext_prev_ff <= 1'b0;
		end else begin
			ext_ff      <= ext_clk;
			ext_prev_ff <= ext_ff;
			if (step)
				cnt_ff <= at_limit ? 6'h00 : cnt_ff + 6'h01;
		end
	end

	property p_tick_gap;
		@(posedge sys_clk) disable iff (srst) tick |=> !tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("prescaler ticked twice in a row");

endmodule : cct_prescaler

// *** hw/cct_timer_pair.sv ***
// Two classic 16-bit counter/timers with modes 13-bit, 16-bit, 8-bit reload and split, plus register port.
// Assumes all pins are synchronous to sys_clk; read data appear only in the cycle after the read strobe.
// Functional notes
// - Each timer is 16 bits, two bytes
// - Two-bit mode per timer, independent
// - Mode 0: high byte plus low five bits
// - Mode 0 low bits 7:5 undefined, ignore
// - 13-bit wrap sets flag, may interrupt
// - Counter mode counts count-pin falling edges
// - Pin sampled synchronously, every clock cycle
// - Timer mode: system clock or prescaler
// - Prescaler divides by 12, 4, 48, ext/8
// - Count only when run and gate allow, except timer 0 high byte and timer 1 while timer 0 is split
// - Gate input must differ from polarity
// - Interrupt forwarded only when enabled
// - Timer 1 mirrors timer 0 controls
// - Overflow pulses exported to other peripherals
// - Mode 1 uses full 16 bits
// - Mode 2 reloads low byte from high
// - Mode 3 high byte is timer 1's
// - Run bit never clears the count
module cct_timer_pair (
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	input  wire cct_pkg::cct_bus_req_s bus_req,
	output logic [7:0]                 rd_data,
	input  wire logic                  timer0_count_pin,
	input  wire logic                  timer1_count_pin,
	input  wire logic                  ext_gate_input_a,
	input  wire logic                  ext_gate_input_b,
	input  wire logic                  ext_clk,
	input  wire logic                  timer0_irq_ack,
	input  wire logic                  timer1_irq_ack,
	output logic                       timer0_irq,
	output logic                       timer1_irq,
	output logic                       timer0_ovf_pulse,
	output logic                       timer1_ovf_pulse
);

	logic [1:0]               run_ff;
	logic [1:0]               flag_ff;
	logic [1:0]               gate_en_ff;
	logic [1:0]               cnt_sel_ff;
	logic [1:0]               sysclk_sel_ff;
	logic [1:0]               pol_ff;
	logic [1:0]               irq_en_ff;
	cct_pkg::cct_mode_e       mode_ff [2];
	cct_pkg::cct_div_e        div_sel_ff;
	logic [7:0]               lo_ff [2];
	logic [7:0]               hi_ff [2];
	logic [1:0]               pin_ff;
	logic [1:0]               pin_prev_ff;
	logic [1:0]               ovf_out_ff;
	logic [7:0]               rd_data_ff;
	logic [7:0]               rd_mux;
	logic [1:0]               nxt_flag;
	logic [7:0]               nxt_lo [2];
	logic [7:0]               nxt_hi [2];
	logic [1:0]               fall;
	logic [1:0]               run_en;
	logic [1:0]               tmr_tick;
	logic [1:0]               src_tick;
	logic [1:0]               cnt_en;
	logic [1:0]               ovf;
	logic [1:0]               flag_set;
	logic                     pre_tick;
	cct_pkg::cct_cnt_s        step [2];

	wire [1:0] pin_in  = {timer1_count_pin, timer0_count_pin};
	wire [1:0] gate_in = {ext_gate_input_b, ext_gate_input_a};
	wire [1:0] ack_in  = {timer1_irq_ack, timer0_irq_ack};

	// Register decode
	wire [7:0] wd       = bus_req.wdata;
	wire       wr_ctrl  = bus_req.wr && bus_req.addr == cct_pkg::OFF_TIMER_CONTROL;
	wire       wr_mode  = bus_req.wr && bus_req.addr == cct_pkg::OFF_TIMER_MODE;
	wire       wr_clk   = bus_req.wr && bus_req.addr == cct_pkg::OFF_CLOCK_CONTROL;
	wire       wr_cfg   = bus_req.wr && bus_req.addr == cct_pkg::OFF_EXT_INPUT_CFG;
	wire       wr_irqen = bus_req.wr && bus_req.addr == cct_pkg::OFF_IRQ_ENABLE;
	wire [1:0] wr_lo    = {bus_req.wr && bus_req.addr == cct_pkg::OFF_TIMER1_LOW,
	                       bus_req.wr && bus_req.addr == cct_pkg::OFF_TIMER0_LOW};
	wire [1:0] wr_hi    = {bus_req.wr && bus_req.addr == cct_pkg::OFF_TIMER1_HIGH,
	                       bus_req.wr && bus_req.addr == cct_pkg::OFF_TIMER0_HIGH};

	// Timer 0 in split mode takes over timer 1's run bit and flag
	wire split       = (mode_ff[0] == cct_pkg::CCT_MODE_SPLIT);
	wire hi_split_en = split & run_ff[1] & tmr_tick[0];
	wire hi_split_ov = hi_split_en & (&hi_ff[0]);

	cct_prescaler u_prescaler (
		.sys_clk (sys_clk),
		.srst    (srst),
		.ext_clk (ext_clk),
		.div_sel (div_sel_ff),
		.tick    (pre_tick)
	);

	function automatic cct_pkg::cct_cnt_s cct_step(input cct_pkg::cct_mode_e mode,
	                                               input logic [7:0] lo, input logic [7:0] hi);
		cct_pkg::cct_cnt_s r;
		logic [12:0]       c13;
		logic [15:0]       c16;
		r   = '{lo: lo, hi: hi, ovf: 1'b0};
		c13 = {hi, lo[4:0]} + 13'h0001;
		c16 = {hi, lo} + 16'h0001;
		unique case (mode)
			cct_pkg::CCT_MODE_13BIT: begin
				// Upper three low bits are left as they were; software masks them
				r.lo  = {lo[7:5], c13[4:0]};
				r.hi  = c13[12:5];
				r.ovf = &{hi, lo[4:0]};
			end
			cct_pkg::CCT_MODE_16BIT: begin
				r.lo  = c16[7:0];
				r.hi  = c16[15:8];
				r.ovf = &{hi, lo};
			end
			cct_pkg::CCT_MODE_8BIT_RELOAD: begin
				r.ovf = &lo;
				r.lo  = (&lo) ? hi : lo + 8'h01;
			end
			cct_pkg::CCT_MODE_SPLIT: begin
				r.ovf = &lo;
				r.lo  = lo + 8'h01;
			end
		endcase
		return r;
	endfunction : cct_step

	for (genvar i = 0; i < 2; i++) begin : g_timer
		assign fall[i]     = pin_prev_ff[i] & ~pin_ff[i];
		assign run_en[i]   = run_ff[i] & (~gate_en_ff[i] | (gate_in[i] ^ pol_ff[i]));
		assign tmr_tick[i] = sysclk_sel_ff[i] | pre_tick;
		assign src_tick[i] = cnt_sel_ff[i] ? fall[i] : tmr_tick[i];
		assign step[i]     = cct_step(mode_ff[i], lo_ff[i], hi_ff[i]);
		assign ovf[i]      = cnt_en[i] & step[i].ovf;
		assign nxt_lo[i]   = wr_lo[i] ? wd : (cnt_en[i] ? step[i].lo : lo_ff[i]);
		assign nxt_flag[i] = flag_set[i] | (wr_ctrl ? wd[i ? cct_pkg::POS_TIMER1_FLAG : cct_pkg::POS_TIMER0_FLAG]
		                                            : flag_ff[i] & ~ack_in[i]);
	end

	assign cnt_en[0] = run_en[0] & src_tick[0];
	// Timer 1 cannot take pin edges while timer 0 is split, and its own split mode stops it
	assign cnt_en[1] = (mode_ff[1] != cct_pkg::CCT_MODE_SPLIT)
	                   & (split ? tmr_tick[1] : run_en[1] & src_tick[1]);
	assign nxt_hi[0] = wr_hi[0] ? wd : (hi_split_en ? hi_ff[0] + 8'h01 : (cnt_en[0] ? step[0].hi : hi_ff[0]));
	assign nxt_hi[1] = wr_hi[1] ? wd : (cnt_en[1] ? step[1].hi : hi_ff[1]);
	assign flag_set  = {split ? hi_split_ov : ovf[1], ovf[0]};

	assign timer0_irq       = flag_ff[0] & irq_en_ff[0];
	assign timer1_irq       = flag_ff[1] & irq_en_ff[1];
	assign timer0_ovf_pulse = ovf_out_ff[0];
	assign timer1_ovf_pulse = ovf_out_ff[1];
	assign rd_data          = rd_data_ff;

	always_comb begin
		unique case (bus_req.addr)
			cct_pkg::OFF_TIMER_CONTROL: rd_mux = {flag_ff[1], run_ff[1], flag_ff[0], run_ff[0], 4'h0};
			cct_pkg::OFF_TIMER_MODE:    rd_mux = {gate_en_ff[1], cnt_sel_ff[1], mode_ff[1],
			                                      gate_en_ff[0], cnt_sel_ff[0], mode_ff[0]};
			cct_pkg::OFF_TIMER0_LOW:    rd_mux = lo_ff[0];
			cct_pkg::OFF_TIMER0_HIGH:   rd_mux = hi_ff[0];
			cct_pkg::OFF_TIMER1_LOW:    rd_mux = lo_ff[1];
			cct_pkg::OFF_TIMER1_HIGH:   rd_mux = hi_ff[1];
			cct_pkg::OFF_CLOCK_CONTROL: rd_mux = {4'h0, sysclk_sel_ff, div_sel_ff};
			cct_pkg::OFF_EXT_INPUT_CFG: rd_mux = {pol_ff[1], 3'h0, pol_ff[0], 3'h0};
			cct_pkg::OFF_IRQ_ENABLE:    rd_mux = {4'h0, irq_en_ff[1], 1'b0, irq_en_ff[0], 1'b0};
			default:                    rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			run_ff        <= 2'h0;
			flag_ff       <= 2'h0;
			gate_en_ff    <= 2'h0;
			cnt_sel_ff    <= 2'h0;
			sysclk_sel_ff <= 2'h0;
			pol_ff        <= 2'h0;
			irq_en_ff     <= 2'h0;
			mode_ff       <= '{cct_pkg::CCT_MODE_13BIT, cct_pkg::CCT_MODE_13BIT};
			div_sel_ff    <= cct_pkg::CCT_DIV_SYS12;
			lo_ff         <= '{cct_pkg::RESET_BYTE, cct_pkg::RESET_BYTE};
			hi_ff         <= '{cct_pkg::RESET_BYTE, cct_pkg::RESET_BYTE};
			pin_ff        <= 2'h3;
			pin_prev_ff   <= 2'h3;
			ovf_out_ff    <= 2'h0;
			rd_data_ff    <= 8'h00;
		end else begin
			pin_ff      <= pin_in;
			pin_prev_ff <= pin_ff;
			flag_ff     <= nxt_flag;
			lo_ff       <= nxt_lo;
			hi_ff       <= nxt_hi;
			ovf_out_ff  <= ovf;
			rd_data_ff  <= bus_req.rd ? rd_mux : 8'h00;
			if (wr_ctrl)
				run_ff <= {wd[cct_pkg::POS_TIMER1_RUN], wd[cct_pkg::POS_TIMER0_RUN]};
			if (wr_mode) begin
				mode_ff[0]    <= cct_pkg::cct_mode_e'(wd[cct_pkg::POS_MODE_LSB +: 2]);
				mode_ff[1]    <= cct_pkg::cct_mode_e'(wd[cct_pkg::POS_MODE_LSB + cct_pkg::MODE_STRIDE +: 2]);
				cnt_sel_ff    <= {wd[cct_pkg::POS_CNT_SELECT + cct_pkg::MODE_STRIDE], wd[cct_pkg::POS_CNT_SELECT]};
				gate_en_ff    <= {wd[cct_pkg::POS_GATE_ENABLE + cct_pkg::MODE_STRIDE], wd[cct_pkg::POS_GATE_ENABLE]};
			end
			if (wr_clk) begin
				div_sel_ff    <= cct_pkg::cct_div_e'(wd[cct_pkg::POS_DIV_LSB +: 2]);
				sysclk_sel_ff <= {wd[cct_pkg::POS_SYSCLK_SEL1], wd[cct_pkg::POS_SYSCLK_SEL0]};
			end
			if (wr_cfg)
				pol_ff <= {wd[cct_pkg::POS_POLARITY1], wd[cct_pkg::POS_POLARITY0]};
			if (wr_irqen)
				irq_en_ff <= {wd[cct_pkg::POS_IRQ_EN1], wd[cct_pkg::POS_IRQ_EN0]};
		end
	end

	// Checks
	property p_run_off_hold;
		@(posedge sys_clk) disable iff (srst)
		!run_ff[0] && !wr_lo[0] |=> $stable(lo_ff[0]);
	endproperty
	a_run_off_hold: assert property (p_run_off_hold) else $error("timer 0 low byte moved while stopped");

	property p_gate_block;
		@(posedge sys_clk) disable iff (srst)
		run_ff[0] && gate_en_ff[0] && (ext_gate_input_a == pol_ff[0]) && !wr_lo[0] |=> $stable(lo_ff[0]);
	endproperty
	a_gate_block: assert property (p_gate_block) else $error("timer 0 counted with gate closed");

	property p_m0_wrap;
		@(posedge sys_clk) disable iff (srst)
		mode_ff[0] == cct_pkg::CCT_MODE_13BIT && cnt_en[0] && {hi_ff[0], lo_ff[0][4:0]} == 13'h1fff
		&& !wr_lo[0] && !wr_hi[0] && !wr_ctrl |=> {hi_ff[0], lo_ff[0][4:0]} == 13'h0000 && flag_ff[0];
	endproperty
	a_m0_wrap: assert property (p_m0_wrap) else $error("13-bit wrap did not clear count and set flag");

	property p_fall_count;
		@(posedge sys_clk) disable iff (srst)
		mode_ff[0] == cct_pkg::CCT_MODE_16BIT && cnt_sel_ff[0] && run_en[0] && fall[0]
		&& !wr_lo[0] && !wr_hi[0] |=> {hi_ff[0], lo_ff[0]} == $past({hi_ff[0], lo_ff[0]}) + 16'h0001;
	endproperty
	a_fall_count: assert property (p_fall_count) else $error("falling pin edge not counted once");

	property p_pin_to_count;
		@(posedge sys_clk) disable iff (srst)
		mode_ff[0] == cct_pkg::CCT_MODE_16BIT && cnt_sel_ff[0] && run_ff[0] && !gate_en_ff[0]
		&& $fell(timer0_count_pin) ##1 (!wr_lo[0] && !wr_hi[0] && !wr_mode && !wr_ctrl)
		|=> {hi_ff[0], lo_ff[0]} != $past({hi_ff[0], lo_ff[0]});
	endproperty
	a_pin_to_count: assert property (p_pin_to_count) else $error("pin edge not counted two cycles later");

	property p_m2_reload;
		@(posedge sys_clk) disable iff (srst)
		mode_ff[1] == cct_pkg::CCT_MODE_8BIT_RELOAD && cnt_en[1] && lo_ff[1] == 8'hff
		&& !wr_lo[1] && !wr_hi[1] |=> lo_ff[1] == $past(hi_ff[1]) && $stable(hi_ff[1]);
	endproperty
	a_m2_reload: assert property (p_m2_reload) else $error("reload mode did not reload low byte");

	property p_split_flag;
		@(posedge sys_clk) disable iff (srst)
		hi_split_ov && !wr_hi[0] |=> flag_ff[1] && hi_ff[0] == 8'h00;
	endproperty
	a_split_flag: assert property (p_split_flag) else $error("split high byte overflow lost");

	property p_flag_sticky;
		@(posedge sys_clk) disable iff (srst)
		flag_ff[0] && !timer0_irq_ack && !wr_ctrl |=> flag_ff[0];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag dropped by itself");

	property p_irq_gate;
		@(posedge sys_clk) disable iff (srst)
		ovf[0] && !wr_irqen |=> (timer0_irq == irq_en_ff[0]) && timer0_ovf_pulse;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt or overflow pulse wrong after overflow");

	c_m2_reload: cover property (@(posedge sys_clk) disable iff (srst)
		mode_ff[1] == cct_pkg::CCT_MODE_8BIT_RELOAD && ovf[1]);
	c_split_high: cover property (@(posedge sys_clk) disable iff (srst) hi_split_ov);
	c_gated_count: cover property (@(posedge sys_clk) disable iff (srst) gate_en_ff[1] && cnt_en[1]);
	c_pin_count: cover property (@(posedge sys_clk) disable iff (srst) cnt_sel_ff[0] && cnt_en[0]);

endmodule : cct_timer_pair

// *** bench/cct_pin_model.sv ***
// Far-side model: count pins, gate inputs and a free-running external clock.
// Assumes the bench calls its tasks from one process at a time.
module cct_pin_model (
	input  wire logic sys_clk,
	output logic      timer0_count_pin,
	output logic      timer1_count_pin,
	output logic      ext_gate_input_a,
	output logic      ext_gate_input_b,
	output logic      ext_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		timer0_count_pin = 1'b1;
		timer1_count_pin = 1'b1;
		ext_gate_input_a = 1'b0;
		ext_gate_input_b = 1'b0;
		ext_clk = 1'b0;
	end
	// Runs free, rising every second cycle
	always @(posedge sys_clk) ext_clk <= ~ext_clk;
	// Each level held two cycles, twice the one-cycle minimum the sampler needs
	task automatic falls(input bit t, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			if (t) timer1_count_pin <= 1'b0;
			else timer0_count_pin <= 1'b0;
			repeat (2) @(posedge sys_clk);
			if (t) timer1_count_pin <= 1'b1;
			else timer0_count_pin <= 1'b1;
			@(posedge sys_clk);
		end
	endtask : falls
	task automatic gate(input bit t, input logic v);
		@(posedge sys_clk);
		if (t) ext_gate_input_b <= v;
		else ext_gate_input_a <= v;
	endtask : gate
endmodule : cct_pin_model

// *** bench/classic_counter_timer_pair_tb.sv ***
// Self-checking bench for the counter/timer pair: register tasks and directed tests.
// Assumes the pin model drives pins and clock source; interrupt acks are driven here.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module classic_counter_timer_pair_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] A_CTL = cct_pkg::OFF_TIMER_CONTROL;
	localparam logic [3:0] A_MOD = cct_pkg::OFF_TIMER_MODE;
	localparam logic [3:0] A_L0  = cct_pkg::OFF_TIMER0_LOW;
	localparam logic [3:0] A_H0  = cct_pkg::OFF_TIMER0_HIGH;
	localparam logic [3:0] A_L1  = cct_pkg::OFF_TIMER1_LOW;
	localparam logic [3:0] A_H1  = cct_pkg::OFF_TIMER1_HIGH;
	localparam logic [3:0] A_CLK = cct_pkg::OFF_CLOCK_CONTROL;
	localparam logic [3:0] A_CFG = cct_pkg::OFF_EXT_INPUT_CFG;
	localparam logic [3:0] A_IEN = cct_pkg::OFF_IRQ_ENABLE;
	logic                  sys_clk;
	logic                  srst;
	logic                  ack0;
	logic                  ack1;
	cct_pkg::cct_bus_req_s bus_req;
	logic [7:0]            rd_data;
	logic [7:0]            v;
	logic                  t0p, t1p, ga, gb, eclk, irq0, irq1, ovf0, ovf1;
	int                    failures, comparisons, n0, n1, base;
	int                    dv [4];
	cct_timer_pair i_dut (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
		.timer0_count_pin(t0p), .timer1_count_pin(t1p), .ext_gate_input_a(ga), .ext_gate_input_b(gb),
		.ext_clk(eclk), .timer0_irq_ack(ack0), .timer1_irq_ack(ack1), .timer0_irq(irq0), .timer1_irq(irq1),
		.timer0_ovf_pulse(ovf0), .timer1_ovf_pulse(ovf1));
	cct_pin_model i_pins (.sys_clk(sys_clk), .timer0_count_pin(t0p), .timer1_count_pin(t1p),
		.ext_gate_input_a(ga), .ext_gate_input_b(gb), .ext_clk(eclk));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Counting high cycles also proves each pulse lasts one cycle
	always @(posedge sys_clk) begin
		if (ovf0 === 1'b1) n0++;
		if (ovf1 === 1'b1) n1++;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req <= '0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req <= '0;
		@(negedge sys_clk);
		d = rd_data;
	endtask : rd
	// Mask drops bits the check must ignore
	task automatic chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		rd(a, v);
		`CHK($sformatf("reg %h", a), e & m, v & m)
	endtask : chk
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask : tdone
	task automatic conclude();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		$display("ERROR watchdog expected done seen hang");
		conclude();
	end
	initial begin
		srst = 1'b1;
		bus_req = '0;
		ack0 = 1'b0;
		ack1 = 1'b0;
		// Ext clock rises every second cycle, so its /8 spans 16 cycles
		dv = '{cct_pkg::DIV_SYS12, cct_pkg::DIV_SYS4, cct_pkg::DIV_SYS48, 2 * cct_pkg::DIV_EXT8};
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		for (int a = 0; a < 10; a++) chk((a == 9) ? 4'hf : 4'(a), 8'hff, cct_pkg::RESET_BYTE);
		wr(A_L0, 8'h55);
		chk(A_L0, 8'hff, 8'h55);
		wr(A_H1, 8'haa);
		chk(A_H1, 8'hff, 8'haa);
		tdone("reset_bytes");
		wr(A_MOD, 8'h04);
		wr(A_H0, 8'hff);
		wr(A_L0, 8'h1e);
		wr(A_CTL, 8'h10);
		i_pins.falls(1'b0, 2);
		repeat (4) @(posedge sys_clk);
		chk(A_CTL, 8'hff, 8'h30);
		`CHK("irq0 masked", 1'b0, irq0)
		wr(A_IEN, 8'h02);
		@(negedge sys_clk);
		`CHK("irq0 enabled", 1'b1, irq0)
		chk(A_L0, 8'h1f, 8'h00);
		chk(A_H0, 8'hff, 8'h00);
		`CHK("ovf0 pulses", 1, n0)
		@(posedge sys_clk);
		ack0 <= 1'b1;
		@(posedge sys_clk);
		ack0 <= 1'b0;
		chk(A_CTL, 8'hff, 8'h10);
		`CHK("irq0 cleared", 1'b0, irq0)
		wr(A_CTL, 8'h30);
		chk(A_CTL, 8'hff, 8'h30);
		wr(A_CTL, 8'h00);
		// Full 16-bit pin counting, so the edge-count checks see their case
		wr(A_MOD, 8'h05);
		wr(A_L0, 8'h05);
		i_pins.falls(1'b0, 3);
		repeat (4) @(posedge sys_clk);
		chk(A_L0, 8'hff, 8'h05);
		wr(A_CTL, 8'h10);
		i_pins.falls(1'b0, 1);
		repeat (4) @(posedge sys_clk);
		chk(A_L0, 8'hff, 8'h06);
		chk(A_H0, 8'hff, 8'h00);
		wr(A_CTL, 8'h00);
		tdone("mode0_counter");
		for (int t = 0; t < 2; t++) for (int c = 0; c < 4; c++) begin
			wr(A_MOD, t ? 8'hc0 : 8'h0c);
			wr(A_CFG, 8'(c[0]) << (t ? 7 : 3));
			i_pins.gate(t, c[1]);
			wr(t ? A_L1 : A_L0, 8'h00);
			wr(A_CTL, t ? 8'h40 : 8'h10);
			i_pins.falls(t, 2);
			repeat (4) @(posedge sys_clk);
			wr(A_CTL, 8'h00);
			chk(t ? A_L1 : A_L0, 8'h1f, (c[0] != c[1]) ? 8'h02 : 8'h00);
		end
		tdone("gate_table");
		wr(A_CLK, 8'h04);
		wr(A_MOD, 8'h01);
		wr(A_H0, 8'hff);
		wr(A_L0, 8'h00);
		wr(A_CTL, 8'h10);
		repeat (100) @(posedge sys_clk);
		chk(A_CTL, 8'h20, 8'h00);
		repeat (200) @(posedge sys_clk);
		chk(A_CTL, 8'h20, 8'h20);
		wr(A_CTL, 8'h00);
		tdone("mode1_sysclk");
		for (int d = 0; d < 4; d++) begin
			wr(A_CLK, 8'(d));
			wr(A_MOD, 8'h10);
			wr(A_H1, 8'hff);
			wr(A_L1, 8'hfc);
			wr(A_CTL, 8'h40);
			repeat (3 * dv[d] - 4) @(posedge sys_clk);
			chk(A_CTL, 8'h80, 8'h00);
			repeat (dv[d] + 6) @(posedge sys_clk);
			chk(A_CTL, 8'h80, 8'h80);
			wr(A_CTL, 8'h00);
		end
		tdone("prescaler");
		wr(A_CLK, 8'h08);
		wr(A_CFG, 8'h80);
		wr(A_MOD, 8'h20);
		wr(A_H1, 8'hf0);
		wr(A_L1, 8'hfe);
		i_pins.gate(1'b1, 1'b1);
		base = n1;
		wr(A_CTL, 8'h40);
		repeat (8) @(posedge sys_clk);
		// Stopping by gate keeps the flag, a control write would overwrite it
		wr(A_MOD, 8'ha0);
		chk(A_CTL, 8'hff, 8'hc0);
		chk(A_H1, 8'hff, 8'hf0);
		rd(A_L1, v);
		`CHK("reload range", 1'b1, v >= 8'hf0)
		`CHK("ovf1 pulses", 1, n1 - base)
		wr(A_IEN, 8'h08);
		@(negedge sys_clk);
		`CHK("irq1 enabled", 1'b1, irq1)
		@(posedge sys_clk);
		ack1 <= 1'b1;
		@(posedge sys_clk);
		ack1 <= 1'b0;
		@(negedge sys_clk);
		`CHK("irq1 cleared", 1'b0, irq1)
		tdone("mode2_reload");
		wr(A_CLK, 8'h04);
		wr(A_MOD, 8'h03);
		wr(A_CTL, 8'h00);
		wr(A_L0, 8'h33);
		wr(A_H0, 8'hfe);
		wr(A_CTL, 8'h40);
		repeat (6) @(posedge sys_clk);
		chk(A_CTL, 8'hff, 8'hc0);
		chk(A_L0, 8'hff, 8'h33);
		`CHK("irq1 split", 1'b1, irq1)
		tdone("mode3_split");
		conclude();
	end
endmodule : classic_counter_timer_pair_tb
